// ---- logic/flic_ctrl.v ----
// The register addresses and register access over APB were decided locally.
`timescale 1ns/100ps
`include "flic_map.vh"
module flic_ctrl #(
  parameter NSRC = 15,
  // polling order, entry 0 (low nibble) polled first
  parameter [59:0] RANK = 60'he_dcba_9876_5432_10
) (
  input  wire        clk_in,
  input  wire        rstn_in,
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [7:0]  paddr_in,
  input  wire [31:0] pwdata_in,
  output reg  [31:0] prdata_out,
  output reg         pready_out,
  output reg         pslverr_out,
  input  wire [1:0]  external_request_pin_in,
  input  wire [12:0] periph_req_in,
  input  wire        instr_start_in,
  input  wire        vector_ack_in,
  input  wire        isr_return_in,
  output reg         irq_req_out,
  output reg  [3:0]  irq_src_out,
  output reg  [1:0]  irq_lvl_out,
  output reg         idle_out,
  output reg         pdown_out,
  output reg         wake_out
);

  ////////////////////////////////////////////////////////////////////
  // registers and state
  reg  [7:0]  enable_reg_a;
  reg  [7:0]  enable_reg_b;
  reg  [7:0]  priority_low_reg_a;
  reg  [7:0]  priority_high_reg_a;
  reg  [7:0]  priority_low_reg_b;
  reg  [7:0]  priority_high_reg_b;
  reg  [1:0]  trig_type;
  reg  [3:0]  in_service;
  wire [1:0]  ext_req;
  wire [1:0]  ext_flag;
  wire [14:0] pending;
  wire [14:0] enables;
  wire [14:0] pri_lo;
  wire [14:0] pri_hi;
  wire [14:0] eligible;
  wire        global_irq_gate;
  wire        wr_en;
  wire        rd_en;
  wire        tctl_wr;
  wire        vec_take;
  reg  [31:0] next_rdata;
  reg         addr_ok;

  ////////////////////////////////////////////////////////////////////
  // source assembly
  // order: ext0, timer0, ext1, timer1, serial combined, serial tx,
  // serial rx, brownout, wdt/rtc, i2c, keyboard, comparators, spi,
  // capture/compare, eeprom write done
  assign pending = {periph_req_in[12:2], periph_req_in[1], ext_req[1],
                    periph_req_in[0], ext_req[0]};
  assign global_irq_gate = enable_reg_a[`FLIC_GATE_BIT];
  assign enables = {enable_reg_b, enable_reg_a[`FLIC_A_SRCS-1:0]};
  assign pri_lo  = {priority_low_reg_b, priority_low_reg_a[6:0]};
  assign pri_hi  = {priority_high_reg_b, priority_high_reg_a[6:0]};
  assign eligible = pending & enables & {NSRC{global_irq_gate}};

  ////////////////////////////////////////////////////////////////////
  // level of one source, two bits, larger is more urgent
  function [1:0] src_level;
    input [14:0] hi;
    input [14:0] lo;
    input [3:0]  s;
    begin
      src_level = {hi[s], lo[s]};
    end
  endfunction

  // highest level set plus one (0 when none) in a one-hot-per-level in-service vector
  function [2:0] top_active;
    input [3:0] act;
    begin
      if (act[3])
        top_active = 3'h4;
      else if (act[2])
        top_active = 3'h3;
      else if (act[1])
        top_active = 3'h2;
      else if (act[0])
        top_active = 3'h1;
      else
        top_active = 3'h0;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // arbitration: highest level first, polling order among equals
  reg        sel_found;
  reg [3:0]  sel_src;
  reg [1:0]  sel_lvl;
  reg [3:0]  cand;
  reg [1:0]  cand_lvl;
  integer    p;
  always @* begin
    sel_found = 1'b0;
    sel_src   = 4'h0;
    sel_lvl   = 2'h0;
    cand      = 4'h0;
    cand_lvl  = 2'h0;
    // walk from last polled to first, so earlier ranks replace ties
    for (p = NSRC - 1; p >= 0; p = p - 1) begin
      cand     = RANK[p*4 +: 4];
      cand_lvl = src_level(pri_hi, pri_lo, cand);
      if (cand < NSRC && eligible[cand]) begin
        if (!sel_found || cand_lvl > sel_lvl) begin
          sel_found = 1'b1;
          sel_src   = cand;
          sel_lvl   = cand_lvl;
        end else if (cand_lvl == sel_lvl) begin // ties only
          sel_src = cand;
        end
      end
    end
  end

  // preemption only by strictly higher level; level 3 blocks all
  wire [2:0] cur_top;
  wire       may_preempt;
  assign cur_top = top_active(in_service);
  assign may_preempt = sel_found && ({1'b0, sel_lvl} + 3'h1 > cur_top);

  ////////////////////////////////////////////////////////////////////
  // request to the core, taken at instruction boundaries
  assign vec_take = irq_req_out & vector_ack_in;
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      irq_req_out <= 1'b0;
      irq_src_out <= 4'h0;
      irq_lvl_out <= 2'h0;
    end else if (vec_take) begin
      irq_req_out <= 1'b0;
    end else if (irq_req_out && !global_irq_gate) begin
      irq_req_out <= 1'b0; // gate closed before vectoring
    end else if (instr_start_in && !irq_req_out && may_preempt) begin
      irq_req_out <= 1'b1; // offer held until acked or gated
      irq_src_out <= sel_src;
      irq_lvl_out <= sel_lvl;
    end
  end

  // in-service levels: set on vectoring, top one cleared on return
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      in_service <= 4'h0;
    end else begin
      if (isr_return_in) begin
        case (cur_top)
          3'h4: in_service[3] <= 1'b0;
          3'h3: in_service[2] <= 1'b0;
          3'h2: in_service[1] <= 1'b0;
          3'h1: in_service[0] <= 1'b0;
          default: in_service <= in_service;
        endcase
      end
      if (vec_take) begin
        in_service[irq_lvl_out] <= 1'b1; // nesting record
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // external input conditioning
  assign tctl_wr = wr_en && (paddr_in == `FLIC_OFS_TCTL);
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_ext
      flic_ext_in u_ext (
        .clk_in       (clk_in),
        .rstn_in      (rstn_in),
        .pin_in       (external_request_pin_in[g]),
        .edge_mode_in (trig_type[g]),
        .hw_clr_in    (vec_take &&
                       irq_src_out == (g == 0 ? `FLIC_SRC_EXT0 : `FLIC_SRC_EXT1)),
        .sw_wr_in     (tctl_wr),
        .sw_val_in    (pwdata_in[2*g+1]),
        .req_out      (ext_req[g]),
        .flag_out     (ext_flag[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // power modes and wake-up
  wire wake_idle;
  wire wake_pd;
  wire ext_enabled_req;
  assign ext_enabled_req = (ext_req[0] & enables[0]) |
                           (ext_req[1] & enables[2]);
  assign wake_idle = idle_out && (|(pending & enables));
  assign wake_pd   = pdown_out && ext_enabled_req;
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      idle_out  <= 1'b0; // reset ends idle
      pdown_out <= 1'b0;
      wake_out  <= 1'b0;
    end else begin
      wake_out <= wake_idle | wake_pd;
      if (wake_idle || wake_pd) begin
        idle_out  <= 1'b0; // wake wins over a same-cycle write
        pdown_out <= 1'b0;
      end else if (wr_en && paddr_in == `FLIC_OFS_POWER) begin
        idle_out  <= pwdata_in[`FLIC_P_IDLE];
        pdown_out <= pwdata_in[`FLIC_P_PDOWN];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, then pready with read data, or an error on any unmapped access, read or write
  assign wr_en = psel_in & penable_in & pready_out & pwrite_in;
  assign rd_en = psel_in & penable_in & ~pready_out;

  // read mux and address check
  always @* begin
    addr_ok    = 1'b1;
    next_rdata = 32'h0000_0000;
    case (paddr_in)
      `FLIC_OFS_EN_A:     next_rdata[7:0] = enable_reg_a;
      `FLIC_OFS_EN_B:     next_rdata[7:0] = enable_reg_b;
      `FLIC_OFS_PRI_LO_A: next_rdata[7:0] = priority_low_reg_a;
      `FLIC_OFS_PRI_HI_A: next_rdata[7:0] = priority_high_reg_a;
      `FLIC_OFS_PRI_LO_B: next_rdata[7:0] = priority_low_reg_b;
      `FLIC_OFS_PRI_HI_B: next_rdata[7:0] = priority_high_reg_b;
      `FLIC_OFS_TCTL:     next_rdata[3:0] = {ext_flag[1], trig_type[1],
                                             ext_flag[0], trig_type[0]};
      `FLIC_OFS_STATUS: begin
        next_rdata[14:0] = pending;
        next_rdata[`FLIC_S_ACT_LSB +: 4] = in_service;
        next_rdata[`FLIC_S_REQ_BIT] = irq_req_out;
      end
      `FLIC_OFS_POWER:    next_rdata[1:0] = {pdown_out, idle_out};
      default: addr_ok = 1'b0;
    endcase
  end

  // handshake and read data
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end else begin
      pready_out  <= psel_in & penable_in & ~pready_out;
      pslverr_out <= rd_en & ~addr_ok;
      if (rd_en && !pwrite_in)
        prdata_out <= next_rdata;
    end
  end

  // writable registers
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      enable_reg_a        <= `FLIC_RST_BYTE;
      enable_reg_b        <= `FLIC_RST_BYTE;
      priority_low_reg_a  <= `FLIC_RST_BYTE;
      priority_high_reg_a <= `FLIC_RST_BYTE;
      priority_low_reg_b  <= `FLIC_RST_BYTE;
      priority_high_reg_b <= `FLIC_RST_BYTE;
      trig_type           <= 2'h0;
    end else if (wr_en) begin
      case (paddr_in)
        `FLIC_OFS_EN_A:     enable_reg_a <= pwdata_in[7:0];
        `FLIC_OFS_EN_B:     enable_reg_b <= pwdata_in[7:0];
        `FLIC_OFS_PRI_LO_A: priority_low_reg_a  <= pwdata_in[7:0];
        `FLIC_OFS_PRI_HI_A: priority_high_reg_a <= pwdata_in[7:0];
        `FLIC_OFS_PRI_LO_B: priority_low_reg_b  <= pwdata_in[7:0];
        `FLIC_OFS_PRI_HI_B: priority_high_reg_b <= pwdata_in[7:0];
        `FLIC_OFS_TCTL: begin
          trig_type[0] <= pwdata_in[`FLIC_T_EXT0_TYPE];
          trig_type[1] <= pwdata_in[`FLIC_T_EXT1_TYPE];
        end
        default: trig_type <= trig_type;
      endcase
    end
  end

endmodule // flic_ctrl

// ---- logic/flic_ext_in.v ----
`timescale 1ns/100ps
// conditions one external request pin: level or falling-edge detection
module flic_ext_in (
  input  wire clk_in,
  input  wire rstn_in,
  input  wire pin_in,
  input  wire edge_mode_in,
  input  wire hw_clr_in,
  input  wire sw_wr_in,
  input  wire sw_val_in,
  output wire req_out,
  output wire flag_out
);

  reg pin_q;
  reg pin_prev;
  reg flag;
  wire fall;

  // sample the pin once per cycle, keep previous sample
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      pin_q    <= 1'b1;
      pin_prev <= 1'b1;
    end else begin
      pin_q    <= pin_in;
      pin_prev <= pin_q;
    end
  end

  assign fall = pin_prev & ~pin_q; // high sample then low sample

  // edge flag: a new edge wins over any clear in the same cycle
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      flag <= 1'b0;
    end else if (edge_mode_in && fall) begin
      flag <= 1'b1;
    end else if (hw_clr_in) begin
      flag <= 1'b0; // cleared on vectoring
    end else if (sw_wr_in) begin
      flag <= sw_val_in;
    end
  end

  // level mode follows the low pin, edge mode uses the flag
  assign req_out  = edge_mode_in ? flag : ~pin_q;
  assign flag_out = flag;

endmodule // flic_ext_in

// ---- logic/flic_map.vh ----
`ifndef FLIC_MAP_VH
`define FLIC_MAP_VH
// register byte offsets
`define FLIC_OFS_EN_A      8'h00
`define FLIC_OFS_EN_B      8'h04
`define FLIC_OFS_PRI_LO_A  8'h08
`define FLIC_OFS_PRI_HI_A  8'h0c
`define FLIC_OFS_PRI_LO_B  8'h10
`define FLIC_OFS_PRI_HI_B  8'h14
`define FLIC_OFS_TCTL      8'h18
`define FLIC_OFS_STATUS    8'h1c
`define FLIC_OFS_POWER     8'h20
// field positions
`define FLIC_GATE_BIT      7
`define FLIC_A_SRCS        7
`define FLIC_T_EXT0_TYPE   0
`define FLIC_T_EXT0_FLAG   1
`define FLIC_T_EXT1_TYPE   2
`define FLIC_T_EXT1_FLAG   3
`define FLIC_P_IDLE        0
`define FLIC_P_PDOWN       1
`define FLIC_S_ACT_LSB     16
`define FLIC_S_REQ_BIT     20
// source indices of the two external inputs
`define FLIC_SRC_EXT0      4'h0
`define FLIC_SRC_EXT1      4'h2
// reset values
`define FLIC_RST_BYTE      8'h00
`define FLIC_RST_TCTL      4'h0
`endif

// ---- tb/flic_core_model.sv ----
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////
// core side: marks instruction boundaries and takes offered vectors
module flic_core_model (
  input  wire       clk_in,
  input  wire       rstn_in,
  input  wire       run_in,
  input  wire [3:0] dly_in,
  input  wire       irq_req_in,
  output reg        instr_start_out = 1'b0,
  output reg        vector_ack_out = 1'b0
);
  reg [3:0] wait_cnt = 4'h0;
  // a boundary each cycle while running; ack once the offer has waited
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      instr_start_out <= 1'b0;
      vector_ack_out  <= 1'b0;
      wait_cnt        <= 4'h0;
    end else begin
      instr_start_out <= run_in;
      vector_ack_out  <= irq_req_in && !vector_ack_out && wait_cnt >= dly_in;
      wait_cnt        <= irq_req_in ? wait_cnt + 4'h1 : 4'h0;
    end
  end
endmodule // flic_core_model

// ---- tb/flic_monitor.sv ----
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////
// watches bus answers, offers to the core and wake events at the ports
module flic_monitor (
  input wire       clk_in,
  input wire       rstn_in,
  input wire       psel_in,
  input wire       penable_in,
  input wire       pready_out,
  input wire       instr_start_in,
  input wire       vector_ack_in,
  input wire       irq_req_out,
  input wire [3:0] irq_src_out,
  input wire [1:0] irq_lvl_out,
  input wire       idle_out,
  input wire       pdown_out,
  input wire       wake_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // bus setup cycle, then first access cycle still waiting
  sequence s_setup; psel_in && !penable_in; endsequence
  sequence s_wait; psel_in && penable_in && !pready_out; endsequence
  property p_one_wait; s_setup ##1 s_wait |=> pready_out; endproperty
  property p_setup_quiet; s_setup |=> !pready_out; endproperty
  property p_offer_cause; $rose(irq_req_out) |-> $past(instr_start_in); endproperty
  property p_offer_ack; irq_req_out && vector_ack_in |=> !irq_req_out; endproperty
  property p_offer_hold; irq_req_out |=> $stable(irq_src_out) && $stable(irq_lvl_out); endproperty
  property p_src_range; irq_req_out |-> irq_src_out <= 4'he; endproperty
  property p_wake_pulse; wake_out |=> !wake_out; endproperty
  property p_wake_ends; $fell(idle_out) || $fell(pdown_out) |-> wake_out || $past(wake_out); endproperty
  a_one_wait: assert property (p_one_wait) else $error("bus answer late");
  a_setup_quiet: assert property (p_setup_quiet) else $error("bus answer early");
  a_offer_cause: assert property (p_offer_cause) else $error("offer off boundary");
  a_offer_ack: assert property (p_offer_ack) else $error("offer kept after ack");
  a_offer_hold: assert property (p_offer_hold) else $error("offer changed");
  a_src_range: assert property (p_src_range) else $error("source out of range");
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake too long");
  a_wake_ends: assert property (p_wake_ends) else $error("sleep ended silently");
endmodule // flic_monitor

bind flic_ctrl flic_monitor u_mon (.clk_in(clk_in), .rstn_in(rstn_in), .psel_in(psel_in),
  .penable_in(penable_in), .pready_out(pready_out), .instr_start_in(instr_start_in),
  .vector_ack_in(vector_ack_in), .irq_req_out(irq_req_out), .irq_src_out(irq_src_out),
  .irq_lvl_out(irq_lvl_out), .idle_out(idle_out), .pdown_out(pdown_out), .wake_out(wake_out));

// ---- tb/tb_four_level_interrupt_controller.sv ----
`timescale 1ns/100ps
`include "flic_map.vh"
module tb_four_level_interrupt_controller;
  reg         clk_in = 1'b0;
  reg         rstn_in = 1'b0;
  reg         psel_in = 1'b0;
  reg         penable_in = 1'b0;
  reg         pwrite_in = 1'b0;
  reg  [7:0]  paddr_in = 8'h00;
  reg  [31:0] pwdata_in = 32'h0;
  reg  [1:0]  pin = 2'h3;
  reg  [12:0] periph = 13'h0;
  reg         isr_ret = 1'b0;
  reg         run = 1'b0;
  reg  [31:0] rd_q;
  reg         rd_e;
  reg  [7:0]  a;
  wire [31:0] prdata_out;
  wire        pready_out, pslverr_out, start, ack, irq_req_out, idle_out, pdown_out, wake_out;
  wire [3:0]  irq_src_out;
  wire [1:0]  irq_lvl_out;
  integer     failures = 0;
  integer     n_compared = 0;
  always #20 clk_in = ~clk_in;
  flic_ctrl dut (.clk_in(clk_in), .rstn_in(rstn_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .external_request_pin_in(pin),
    .periph_req_in(periph), .instr_start_in(start), .vector_ack_in(ack), .isr_return_in(isr_ret),
    .irq_req_out(irq_req_out), .irq_src_out(irq_src_out), .irq_lvl_out(irq_lvl_out),
    .idle_out(idle_out), .pdown_out(pdown_out), .wake_out(wake_out));
  flic_core_model core (.clk_in(clk_in), .rstn_in(rstn_in), .run_in(run), .dly_in(4'h2),
    .irq_req_in(irq_req_out), .instr_start_out(start), .vector_ack_out(ack));
  ////////////////////////////////////////////////////////////////////////
  task end_of_test;
    begin
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // one bus transfer, held until the slave answers
  task apb(input w, input [7:0] ad, input [31:0] d);
    integer k;
    begin
      @(posedge clk_in);
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= ad;
      pwdata_in <= d;
      @(posedge clk_in);
      penable_in <= 1'b1;
      k = 0;
      @(posedge clk_in);
      while (pready_out !== 1'b1) begin
        k = k + 1;
        if (k > 20) begin
          failures = failures + 1;
          end_of_test;
        end
        @(posedge clk_in);
      end
      rd_q = prdata_out;
      rd_e = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
    end
  endtask
  task rdc(input [7:0] ad, input [31:0] exp, input e);
    begin
      apb(1'b0, ad, 32'h0);
      chk(rd_q, exp);
      chk({31'h0, rd_e}, {31'h0, e});
    end
  endtask
  task wait_irq(input [3:0] s, input [1:0] l);
    integer k;
    begin
      k = 0;
      while (irq_req_out !== 1'b1 && k < 30) begin
        @(posedge clk_in);
        k = k + 1;
      end
      chk({31'h0, irq_req_out}, 32'h1);
      if (k >= 30) end_of_test;
      chk({26'h0, irq_src_out, irq_lvl_out}, {26'h0, s, l});
      repeat (6) @(posedge clk_in);
    end
  endtask
  task no_irq;
    repeat (12) begin
      @(posedge clk_in);
      chk({31'h0, irq_req_out}, 32'h0);
    end
  endtask
  task ret;
    begin
      @(posedge clk_in);
      isr_ret <= 1'b1;
      @(posedge clk_in);
      isr_ret <= 1'b0;
    end
  endtask
  task wait_wake;
    integer k;
    begin
      k = 0;
      while (wake_out !== 1'b1 && k < 30) begin
        @(posedge clk_in);
        k = k + 1;
      end
      chk({31'h0, wake_out}, 32'h1);
      if (k >= 30) end_of_test;
      @(posedge clk_in);
      chk({30'h0, idle_out, pdown_out}, 32'h0);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // reset values of every register, then an unmapped address
  task t_reset_values;
    begin
      for (a = 8'h00; a <= 8'h20; a = a + 8'h04) rdc(a, 32'h0, 1'b0);
      rdc(8'h24, 32'h0, 1'b1);
    end
  endtask
  // global gate and individual enables
  task t_gate_enable;
    begin
      apb(1'b1, `FLIC_OFS_EN_A, 32'h02);
      periph <= 13'h3;
      no_irq;
      apb(1'b1, `FLIC_OFS_EN_A, 32'h82);
      wait_irq(4'h1, 2'h0);
      periph <= 13'h0;
      ret;
    end
  endtask
  // level selection, preemption and nesting up to the top level
  task t_levels;
    begin
      apb(1'b1, `FLIC_OFS_EN_A, 32'h8a);
      apb(1'b1, `FLIC_OFS_PRI_LO_A, 32'h02);
      apb(1'b1, `FLIC_OFS_PRI_HI_A, 32'h08);
      periph <= 13'h3;
      wait_irq(4'h3, 2'h2);
      no_irq;
      apb(1'b1, `FLIC_OFS_EN_A, 32'h9a);
      apb(1'b1, `FLIC_OFS_PRI_LO_A, 32'h12);
      apb(1'b1, `FLIC_OFS_PRI_HI_A, 32'h18);
      periph <= 13'h7;
      wait_irq(4'h4, 2'h3);
      apb(1'b1, `FLIC_OFS_EN_A, 32'hba);
      apb(1'b1, `FLIC_OFS_PRI_LO_A, 32'h32);
      apb(1'b1, `FLIC_OFS_PRI_HI_A, 32'h38);
      periph <= 13'hf;
      no_irq;
      periph <= 13'h0;
      ret;
      ret;
    end
  endtask
  // equal levels resolved by the polling order
  task t_tie;
    begin
      apb(1'b1, `FLIC_OFS_PRI_LO_A, 32'h00);
      apb(1'b1, `FLIC_OFS_PRI_HI_A, 32'h00);
      periph <= 13'h3;
      wait_irq(4'h1, 2'h0);
      periph <= 13'h0;
      ret;
    end
  endtask
  // first external input in edge mode, then in level mode
  task t_ext0;
    begin
      apb(1'b1, `FLIC_OFS_EN_A, 32'h81);
      apb(1'b1, `FLIC_OFS_TCTL, 32'h01);
      pin <= 2'h2;
      wait_irq(4'h0, 2'h0);
      rdc(`FLIC_OFS_TCTL, 32'h01, 1'b0);
      ret;
      no_irq;
      apb(1'b1, `FLIC_OFS_TCTL, 32'h00);
      wait_irq(4'h0, 2'h0);
      pin <= 2'h3;
      ret;
      no_irq;
    end
  endtask
  // second external input in edge mode
  task t_ext1;
    begin
      apb(1'b1, `FLIC_OFS_EN_A, 32'h84);
      apb(1'b1, `FLIC_OFS_TCTL, 32'h04);
      pin <= 2'h1;
      wait_irq(4'h2, 2'h0);
      pin <= 2'h3;
      ret;
    end
  endtask
  // idle ended by an enabled peripheral source, gate closed
  task t_wake_idle;
    begin
      apb(1'b1, `FLIC_OFS_EN_A, 32'h02);
      apb(1'b1, `FLIC_OFS_POWER, 32'h01);
      @(posedge clk_in);
      chk({31'h0, idle_out}, 32'h1);
      periph <= 13'h1;
      wait_wake;
      periph <= 13'h0;
    end
  endtask
  // power-down ended by an enabled external request
  task t_wake_pdown;
    begin
      apb(1'b1, `FLIC_OFS_TCTL, 32'h00);
      apb(1'b1, `FLIC_OFS_EN_A, 32'h01);
      apb(1'b1, `FLIC_OFS_POWER, 32'h02);
      @(posedge clk_in);
      chk({31'h0, pdown_out}, 32'h1);
      pin <= 2'h2;
      wait_wake;
      pin <= 2'h3;
    end
  endtask
  // software-set flags, then a reset in mid-run that ends idle
  task t_mid_reset;
    begin
      apb(1'b1, `FLIC_OFS_TCTL, 32'h0a);
      rdc(`FLIC_OFS_TCTL, 32'h0a, 1'b0);
      apb(1'b1, `FLIC_OFS_POWER, 32'h01);
      @(posedge clk_in);
      chk({31'h0, idle_out}, 32'h1);
      rstn_in <= 1'b0;
      // held three edges so every flop has settled before release
      repeat (3) @(posedge clk_in);
      rstn_in <= 1'b1;
      @(posedge clk_in);
      chk({31'h0, idle_out}, 32'h0);
      rdc(`FLIC_OFS_TCTL, 32'h00, 1'b0);
      rdc(`FLIC_OFS_EN_A, 32'h00, 1'b0);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // reset, then every scenario in turn
  initial begin
    repeat (2) @(posedge clk_in);
    rstn_in <= 1'b1;
    run <= 1'b1;
    t_reset_values;
    t_gate_enable;
    t_levels;
    t_tie;
    t_ext0;
    t_ext1;
    t_wake_idle;
    t_wake_pdown;
    t_mid_reset;
    end_of_test;
  end
endmodule // tb_four_level_interrupt_controller
